// File: logic/fpu_unpack.sv
// Top: floating-point operand format unit, widen, unpack, classify, flag unordered (NaN) operands
module fpu_unpack
  import fpu_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic float_available_bit,
  input wire logic little_endian,
  input fpu_pkg::fpu_req_t req_a,
  input wire logic [DP_WIDTH-1:0] float_register_entry_b,
  output logic [DP_WIDTH-1:0] float_register_entry,
  output fpu_pkg::fpu_unpacked_t operand_r,
  output logic out_valid_r,
  output logic unavailable_r,
  output logic operand_reject_r,
  output logic unordered_r,
  output logic big_endian_r
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [DP_WIDTH-1:0] reg_r, reg_nxt;
  fpu_unpacked_t op_nxt, unp;
  logic valid_nxt, unav_nxt, rej_nxt, unord_nxt, be_nxt;
  logic [DP_WIDTH-1:0] wide;
  logic [DP_WIDTH-1:0] merged;
  logic [SP_EXP_W-1:0] se;
  logic [DP_EXP_W-1:0] de;
  logic [2:0] lane;
  logic a_nan, b_nan;

  fpu_classify u_cls (
    .value(wide),
    .bias(DP_BIAS),
    .result(unp)
  );

  // ------------------------------------------------------------
  // Widen and merge
  // ------------------------------------------------------------
  always_comb begin
    se = req_a.data[SP_SIGN_POS-1:SP_EXP_LSB];
    // Special encodings keep their all-ones/zero meaning when widened
    if (&se) de = '1;
    else if (se == '0) de = '0;
    else de = {3'h0, se} + SP_TO_DP_REBIAS;
    // Single denormals become normal in double; exponent arithmetic rebias is exact
    if (req_a.single_src) begin
      wide = {req_a.data[SP_SIGN_POS], de, req_a.data[SP_FRAC_W-1:0], 29'h0};
    end else begin
      wide = req_a.data;
    end
    if (se == '0 && req_a.single_src && req_a.data[SP_FRAC_W-1:0] != '0) begin
      wide = {req_a.data[SP_SIGN_POS], 11'h381, 52'h0};
      for (int i = SP_FRAC_W - 1; i >= 0; i--) begin
        if (req_a.data[i] && wide[DP_FRAC_W-1:0] == '0) begin
          wide[DP_SIGN_POS-1:DP_EXP_LSB] = 11'(11'h381 - 11'(SP_FRAC_W - i));
          wide[DP_FRAC_W-1:0] = 52'({req_a.data[SP_FRAC_W-1:0], 29'h0} << (SP_FRAC_W - i));
        end
      end
    end
    // Byte lane selection honours byte order
    merged = reg_r;
    lane = big_endian_r ? req_a.byte_sel : ~req_a.byte_sel;
    for (int b = 0; b < 8; b++) begin
      if ((req_a.part_size == 2'h0 && 3'(b) == lane) ||
          (req_a.part_size == 2'h1 && 2'(b >> 1) == lane[2:1]) ||
          (req_a.part_size == 2'h2 && 1'(b >> 2) == lane[2])) begin
        merged[8*(7-b) +: 8] = req_a.data[8*(7-b) +: 8];
      end
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    reg_nxt = reg_r;
    op_nxt = operand_r;
    valid_nxt = 1'b0;
    unav_nxt = 1'b0;
    rej_nxt = 1'b0;
    be_nxt = ~little_endian;
    a_nan = unp.cls inside {FPU_CLS_SNAN, FPU_CLS_QNAN};
    b_nan = (&float_register_entry_b[DP_SIGN_POS-1:DP_EXP_LSB]) &&
            (float_register_entry_b[DP_FRAC_W-1:0] != '0);
    unord_nxt = 1'b0;
    if (req_a.valid && req_a.op != FPU_OP_NONE) begin
      if (!float_available_bit) begin
        unav_nxt = 1'b1;
      end else if (req_a.op == FPU_OP_ARITH && req_a.single_op && !req_a.single_src) begin
        rej_nxt = 1'b1;
      end else begin
        valid_nxt = 1'b1;
        op_nxt = unp;
        unord_nxt = a_nan || b_nan;
        if (req_a.op == FPU_OP_MOVE) begin
          reg_nxt = req_a.partial ? merged : wide;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_r <= '0;
      operand_r <= '0;
      out_valid_r <= 1'b0;
      unavailable_r <= 1'b0;
      operand_reject_r <= 1'b0;
      unordered_r <= 1'b0;
      big_endian_r <= RESET_BIG_ENDIAN;
    end else begin
      reg_r <= reg_nxt;
      operand_r <= op_nxt;
      out_valid_r <= valid_nxt;
      unavailable_r <= unav_nxt;
      operand_reject_r <= rej_nxt;
      unordered_r <= unord_nxt;
      big_endian_r <= be_nxt;
    end
  end

  assign float_register_entry = reg_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_req_ok;
    req_a.valid && req_a.op != FPU_OP_NONE && float_available_bit;
  endsequence

  chk_avail_gate: assert property ((req_a.valid && req_a.op != FPU_OP_NONE && !float_available_bit)
    |=> unavailable_r && !out_valid_r) else $error("op ran while unavailable");
  chk_single_reject: assert property (s_req_ok and (req_a.op == FPU_OP_ARITH && req_a.single_op
    && !req_a.single_src) |=> operand_reject_r) else $error("double into single op");
  chk_inf_class: assert property (out_valid_r && &operand_r.biased_exponent_field
    |-> operand_r.cls inside {FPU_CLS_INF, FPU_CLS_SNAN, FPU_CLS_QNAN}) else $error("bad max class");
  chk_implied_bit: assert property (out_valid_r |-> operand_r.significand[DP_FRAC_W]
    == (operand_r.biased_exponent_field != '0)) else $error("implied bit wrong");
  chk_unbias: assert property (out_valid_r && operand_r.cls == FPU_CLS_NORM |->
    operand_r.true_exp == $signed({2'b00, operand_r.biased_exponent_field}) - 13'sd1023)
    else $error("unbias wrong");
  chk_snan_msb: assert property (out_valid_r && operand_r.cls == FPU_CLS_SNAN |->
    !operand_r.significand[DP_FRAC_W-1]) else $error("snan msb set");
  chk_widen_sign: assert property (s_req_ok and (req_a.op == FPU_OP_MOVE && req_a.single_src
    && !req_a.partial) |=> float_register_entry[DP_SIGN_POS] == $past(req_a.data[SP_SIGN_POS]))
    else $error("widen sign lost");
  chk_nan_unord: assert property (out_valid_r && operand_r.cls inside {FPU_CLS_SNAN, FPU_CLS_QNAN}
    |-> unordered_r) else $error("nan ordered");
  chk_reset_be: assert property ($fell(rst) |-> big_endian_r) else $error("not big endian");
endmodule

// File: logic/fpu_pkg.sv
// Package: floating-point operand format constants and carrier types
package fpu_pkg;
  localparam int SP_WIDTH = 32;
  localparam int DP_WIDTH = 64;
  localparam int SP_EXP_W = 8;
  localparam int DP_EXP_W = 11;
  localparam int SP_FRAC_W = 23;
  localparam int DP_FRAC_W = 52;
  localparam int SP_SIGN_POS = 31;
  localparam int DP_SIGN_POS = 63;
  localparam int SP_EXP_LSB = 23;
  localparam int DP_EXP_LSB = 52;
  localparam int EXP_HEADROOM = 2;
  localparam int UEXP_W = DP_EXP_W + EXP_HEADROOM;
  localparam logic [UEXP_W-1:0] SP_BIAS = 13'h007f;
  localparam logic [UEXP_W-1:0] DP_BIAS = 13'h03ff;
  localparam logic [DP_EXP_W-1:0] SP_TO_DP_REBIAS = 11'h380;
  localparam logic RESET_BIG_ENDIAN = 1'b1;

  typedef enum logic [1:0] {FPU_OP_NONE, FPU_OP_ARITH, FPU_OP_MOVE} fpu_op_t;
  typedef enum logic [2:0] {FPU_CLS_ZERO, FPU_CLS_DENORM, FPU_CLS_NORM, FPU_CLS_INF,
                            FPU_CLS_SNAN, FPU_CLS_QNAN} fpu_class_t;

  typedef struct packed {
    logic valid;
    fpu_op_t op;
    logic single_op;
    logic single_src;
    logic partial;
    logic [2:0] byte_sel;
    logic [1:0] part_size;
    logic [DP_WIDTH-1:0] data;
  } fpu_req_t;

  typedef struct packed {
    logic sign;
    logic [DP_EXP_W-1:0] biased_exponent_field;
    logic signed [UEXP_W-1:0] true_exp;
    logic [DP_FRAC_W:0] significand;
    fpu_class_t cls;
  } fpu_unpacked_t;
endpackage

// File: logic/fpu_classify.sv
// Leaf: classify one double-layout value and unbias its exponent
module fpu_classify
  import fpu_pkg::*;
(
  input wire logic [DP_WIDTH-1:0] value,
  input wire logic [UEXP_W-1:0] bias,
  output fpu_pkg::fpu_unpacked_t result
);
  logic [DP_EXP_W-1:0] e;
  logic [DP_FRAC_W-1:0] f;
  logic e_ones;
  logic e_zero;

  always_comb begin
    e = value[DP_SIGN_POS-1:DP_EXP_LSB];
    f = value[DP_FRAC_W-1:0];
    e_ones = &e;
    e_zero = ~|e;
    result.sign = value[DP_SIGN_POS];
    result.biased_exponent_field = e;
    // Denormals use Emin, i.e. biased 1, which the two headroom bits absorb
    result.true_exp = $signed({2'b00, (e_zero ? 11'h001 : e)}) - $signed(bias);
    result.significand = {~e_zero, f};
    if (e_ones) begin
      if (f == '0) result.cls = FPU_CLS_INF;
      else if (f[DP_FRAC_W-1]) result.cls = FPU_CLS_QNAN;
      else result.cls = FPU_CLS_SNAN;
    end else if (e_zero) begin
      result.cls = (f == '0) ? FPU_CLS_ZERO : FPU_CLS_DENORM;
    end else begin
      result.cls = FPU_CLS_NORM;
    end
  end
endmodule

// File: test/fou_core_model.sv
// Core-side model: the load path that hands requests to the operand unit
module fou_core_model
  import fpu_pkg::*;
(
  input wire logic clock,
  output fpu_pkg::fpu_req_t req_a,
  output logic [DP_WIDTH-1:0] float_register_entry_b
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    req_a = '0;
    float_register_entry_b = '0;
  end

  // Held across the taking edge, then withdrawn
  task automatic issue(input fpu_req_t r, input logic [DP_WIDTH-1:0] b);
    @(posedge clock);
    #1;
    req_a = r;
    req_a.valid = 1'b1;
    float_register_entry_b = b;
    @(posedge clock);
    #1;
    req_a.valid = 1'b0;
    // Stale data is inverted so nothing leans on it
    req_a.data = ~req_a.data;
    float_register_entry_b = ~b;
  endtask
endmodule

// File: test/fp_operand_format_unpack_tb.sv
// Testbench for the floating-point operand format unit
module fp_operand_format_unpack_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fpu_pkg::*;

  logic clock = 0;
  logic rst = 1;
  logic avail = 1;
  logic le = 0;
  fpu_req_t req_a;
  logic [63:0] entry_b;
  logic [63:0] entry;
  fpu_unpacked_t opnd;
  logic ov, unav, rej, unord, be;
  int num_errors = 0;
  int num_checks = 0;

  always #50 clock = ~clock;

  fou_core_model u_core (.clock(clock), .req_a(req_a), .float_register_entry_b(entry_b));

  fpu_unpack dut (.clock(clock), .rst(rst), .float_available_bit(avail), .little_endian(le),
    .req_a(req_a), .float_register_entry_b(entry_b), .float_register_entry(entry),
    .operand_r(opnd), .out_valid_r(ov), .unavailable_r(unav), .operand_reject_r(rej),
    .unordered_r(unord), .big_endian_r(be));

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Flags are {single_op, single_src, partial}
  task automatic go(input fpu_op_t op, input logic [2:0] f, input logic [2:0] sel, input logic [63:0] d,
                    input logic [63:0] b);
    fpu_req_t r;
    r = '0;
    r.op = op;
    {r.single_op, r.single_src, r.partial} = f;
    r.byte_sel = sel;
    r.data = d;
    u_core.issue(r, b);
  endtask

  task automatic t_single;
    go(FPU_OP_MOVE, 3'b010, 0, 64'h3f800000, 0);
    chk("entry", 64'h3ff0000000000000, entry);
    chk("true_exp", 64'h0, opnd.true_exp);
    chk("significand", 64'h10000000000000, opnd.significand);
    go(FPU_OP_MOVE, 3'b010, 0, 64'hbf000000, 0);
    chk("entry", 64'hbfe0000000000000, entry);
    chk("true_exp", 64'hffffffffffffffff, opnd.true_exp);
    go(FPU_OP_MOVE, 3'b010, 0, 64'h00000001, 0);
    chk("entry", 64'h36a0000000000000, entry);
  endtask

  task automatic t_classes;
    logic [63:0] v[8] = '{64'h3ff0000000000000, 64'h7fe0000000000000, 64'h0010000000000000,
      64'h8000000000000001, 0, 64'h7ff0000000000000, 64'h7ff0000000000001, 64'h7ff8000000000000};
    fpu_class_t c[8] = '{FPU_CLS_NORM, FPU_CLS_NORM, FPU_CLS_NORM, FPU_CLS_DENORM, FPU_CLS_ZERO,
      FPU_CLS_INF, FPU_CLS_SNAN, FPU_CLS_QNAN};
    logic signed [12:0] x[4] = '{13'h0, 13'h3ff, 13'h1c02, 13'h1c02};
    for (int i = 0; i < 8; i++) begin
      go(FPU_OP_ARITH, 3'b000, 0, v[i], 64'h3ff0000000000000);
      chk("class", c[i], opnd.cls);
      chk("sign", v[i][63], opnd.sign);
      chk("exp_field", v[i][62:52], opnd.biased_exponent_field);
      chk("unordered", i >= 6, unord);
      if (i < 4) chk("true_exp", x[i], opnd.true_exp);
    end
    go(FPU_OP_ARITH, 3'b000, 0, 64'h3ff0000000000000, 64'h7ff8000000000000);
    chk("unordered", 1, unord);
  endtask

  task automatic t_refused;
    avail = 0;
    go(FPU_OP_MOVE, 3'b010, 0, 64'h40000000, 0);
    chk("answer", 3'b010, {ov, unav, rej});
    chk("entry", 64'h36a0000000000000, entry);
    avail = 1;
    go(FPU_OP_ARITH, 3'b100, 0, 64'h4000000000000000, 0);
    chk("answer", 3'b001, {ov, unav, rej});
    go(FPU_OP_ARITH, 3'b110, 0, 64'h40000000, 0);
    chk("answer", 3'b100, {ov, unav, rej});
    chk("entry", 64'h36a0000000000000, entry);
  endtask

  task automatic t_partial;
    go(FPU_OP_MOVE, 3'b000, 0, 0, 0);
    go(FPU_OP_MOVE, 3'b001, 0, 64'haa00000000000000, 0);
    chk("entry", 64'haa00000000000000, entry);
    le = 1;
    go(FPU_OP_MOVE, 3'b001, 0, 64'hbb, 0);
    chk("big_endian", 0, be);
    chk("entry", 64'haa000000000000bb, entry);
    le = 0;
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    #1;
    rst = 0;
    chk("big_endian", 1, be);
    chk("answer", 3'b000, {ov, unav, rej});
    t_single();
    t_classes();
    t_refused();
    t_partial();
    tally_and_finish();
  end

  // Whole run needs well under 200 cycles
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
